// ==== nep_ctrl.sv ====
// eeprom page mapping, nvm control registers and key range decode over apb
`timescale 1ns/10ps
`include "nep_params.svh"
module nep_ctrl
  import nep_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] nv_options,
  input wire logic [7:0] nv_config,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_write,
  output logic flash_cmd_start,
  output logic [2:0] flash_cmd_index,
  output logic [7:0] flash_cmd_data,
  output logic [63:0] backdoor_compare_key,
  output logic eeprom_page_select,
  output logic sector_mapping_mode_bit
);
  typedef struct packed {
    nep_state_t st;
    logic [7:0] clkdiv;
    logic [7:0] options;
    logic [7:0] config_r;
    logic div_err;
    logic done;
    logic [7:0] cmd;
    logic [8:0] tgt;
    logic [7:0] tdata;
    logic [2:0] cnt;
    logic [4:0] tmr;
    logic rd_pend;
    logic [31:0] rdata;
    logic pslverr;
    logic strap_done;
    logic [2:0] cw_sync;
    logic cw_level;
    logic cmd_start;
    logic [2:0] cmd_idx;
    logic [7:0] cmd_data;
  } nep_state_s_t;

  nep_state_s_t s_q;
  nep_state_s_t s_d;
  nep_mem_req_t mreq;
  logic [7:0] mem_rdata;
  logic key_we;
  logic [2:0] key_idx;
  logic [7:0] key_wdata;
  logic setup_w;
  logic acc;
  logic in_key;
  logic cw_rise;
  logic [7:0] ee_off;
  logic [8:0] ee_phys;

  assign setup_w = psel && !penable;
  assign acc = psel && penable && pready;
  assign ee_off = paddr[9:2];
  assign in_key = cpu_addr >= `NEP_CPU_KEY_LO && cpu_addr <= `NEP_CPU_KEY_HI;
  // cpu write strobe arrives from another domain; act once 2nd and 3rd agree
  // address and data are held by the writer well past this point, so they need no sync
  assign cw_rise = s_q.cw_sync[1] && s_q.cw_sync[2] && !s_q.cw_level;

  // map an 8-bit window offset to a physical byte; only one half is seen
  always_comb begin
    if (!s_q.options[`NEP_OPT_SECMODE]) begin
      // four bytes of each sector per page at the same addresses
      ee_phys = {ee_off[7:2], 3'b000} | {6'h00, s_q.config_r[`NEP_CFG_PGSEL],
                ee_off[1:0]};
    end else begin
      // whole sectors swap with the page select
      ee_phys = {s_q.config_r[`NEP_CFG_PGSEL], ee_off};
    end
  end

  // window reads wait one cycle for the array; register reads do not wait
  assign pready = !(psel && penable && !pwrite && paddr >= `NEP_OFF_EE_BASE
                   && !s_q.rd_pend);
  assign prdata = s_q.rdata;
  assign pslverr = s_q.pslverr;
  assign flash_cmd_start = s_q.cmd_start;
  assign flash_cmd_index = s_q.cmd_idx;
  assign flash_cmd_data = s_q.cmd_data;
  assign eeprom_page_select = s_q.config_r[`NEP_CFG_PGSEL];
  assign sector_mapping_mode_bit = s_q.options[`NEP_OPT_SECMODE];

  always_comb begin
    s_d = s_q;
    mreq = '0;
    key_we = 1'b0;
    key_idx = 3'd0;
    key_wdata = 8'h00;
    s_d.cmd_start = 1'b0;
    s_d.done = s_q.done;
    s_d.cw_sync = {s_q.cw_sync[1:0], cpu_write};
    // the settled level moves only when the second and third stages agree
    if (s_q.cw_sync[1] == s_q.cw_sync[2]) begin
      s_d.cw_level = s_q.cw_sync[2];
    end
    s_d.rd_pend = 1'b0;
    // nonvolatile options and the config page select bit copied once after reset release
    if (!s_q.strap_done) begin
      s_d.options = nv_options;
      s_d.config_r = nv_config & 8'h40;
      s_d.strap_done = 1'b1;
    end
    // key range writes from the cpu side
    if (cw_rise && in_key) begin
      if (s_q.config_r[`NEP_CFG_KEYWEN]) begin
        key_we = 1'b1;
        key_idx = cpu_addr[2:0];
        key_wdata = cpu_wdata;
      end else begin
        s_d.cmd_start = 1'b1;
        s_d.cmd_idx = cpu_addr[2:0];
        s_d.cmd_data = cpu_wdata;
      end
    end
    // read data and error are built in setup so both stand through the access phase
    if (setup_w) begin
      s_d.pslverr = 1'b0;
      s_d.rdata = 32'h0000_0000;
      if (paddr < `NEP_OFF_EE_BASE) begin
        unique case (paddr)
          `NEP_OFF_CLKDIV: s_d.rdata = {24'h000000, s_q.clkdiv};
          `NEP_OFF_OPTIONS: s_d.rdata = {24'h000000, s_q.options};
          `NEP_OFF_CONFIG: s_d.rdata = {24'h000000, s_q.config_r};
          `NEP_OFF_STATUS: begin
            s_d.rdata = {24'h000000, s_q.done, s_q.st != NEP_IDLE, 1'b0, s_q.div_err,
                         4'h0};
          end
          `NEP_OFF_COMMAND: s_d.rdata = {24'h000000, s_q.cmd};
          `NEP_OFF_KEY_ADDR: s_d.rdata = {23'h0, s_q.tgt};
          `NEP_OFF_KEY_DATA: s_d.rdata = {24'h000000, s_q.tdata};
          default: s_d.pslverr = 1'b1;
        endcase
      end
    end
    // window reads: the array is addressed from setup on and its byte is taken in the
    // first access cycle; a read that meets an operation's array write sees that write's
    // address instead, so software waits for done before it reads the window
    if (psel && !pwrite && paddr >= `NEP_OFF_EE_BASE) begin
      mreq.addr = ee_phys;
    end
    if (psel && penable && !pwrite && paddr >= `NEP_OFF_EE_BASE && !s_q.rd_pend) begin
      s_d.rdata = {24'h000000, mem_rdata};
      s_d.rd_pend = 1'b1;
    end
    // register writes land only at the edge that completes the transfer
    if (acc && pwrite && paddr < `NEP_OFF_EE_BASE) begin
      unique case (paddr)
        `NEP_OFF_CLKDIV: begin
          // bits 6:0 accept the first write only; bit 7 records that it happened
          if (!s_q.clkdiv[`NEP_DIV_LOADED]) begin
            s_d.clkdiv = {1'b1, pwdata[6:0]};
          end
        end
        `NEP_OFF_CONFIG: s_d.config_r = pwdata[7:0] & 8'h60;
        `NEP_OFF_STATUS: begin
          // write one to clear; an engine set later in this process wins
          if (pwdata[`NEP_ST_DIVERR]) begin
            s_d.div_err = 1'b0;
          end
          if (pwdata[`NEP_ST_DONE]) begin
            s_d.done = 1'b0;
          end
        end
        `NEP_OFF_COMMAND: s_d.cmd = pwdata[7:0];
        `NEP_OFF_KEY_ADDR: s_d.tgt = pwdata[8:0];
        `NEP_OFF_KEY_DATA: s_d.tdata = pwdata[7:0];
        default: begin
          // options is read-only and unmapped offsets take no write
        end
      endcase
    end
    // operation engine; a launch is a write to command with a legal code once the divider is loaded
    unique case (s_q.st)
      NEP_IDLE: begin
        if (acc && pwrite && paddr == `NEP_OFF_COMMAND) begin
          if (!s_q.clkdiv[`NEP_DIV_LOADED]) begin
            s_d.div_err = 1'b1;
          end else if (pwdata[7:0] == `NEP_CMD_PROGRAM) begin
            s_d.st = NEP_RUN;
            s_d.tmr = 5'(`NEP_OP_CYCLES);
          end else if (pwdata[7:0] == `NEP_CMD_SECT_ERASE) begin
            s_d.st = NEP_ERASE;
            s_d.cnt = 3'd0;
          end
        end
      end
      NEP_RUN: begin
        // program lands in the foreground page via the same mapping
        if (s_q.tmr == 5'd0) begin
          mreq.we = 1'b1;
          mreq.addr = s_q.options[`NEP_OPT_SECMODE] ?
                      {s_q.config_r[`NEP_CFG_PGSEL], s_q.tgt[7:0]} :
                      {s_q.tgt[7:2], s_q.config_r[`NEP_CFG_PGSEL], s_q.tgt[1:0]};
          mreq.wdata = s_q.tdata;
          s_d.st = NEP_IDLE;
          s_d.done = 1'b1;
        end else begin
          s_d.tmr = s_q.tmr - 5'd1;
        end
      end
      NEP_ERASE: begin
        // mode 0 walks all eight physical bytes; mode 1 the foreground sector
        mreq.we = 1'b1;
        mreq.wdata = `NEP_ERASED;
        if (!s_q.options[`NEP_OPT_SECMODE]) begin
          mreq.addr = {s_q.tgt[7:2], s_q.cnt};
        end else begin
          mreq.addr = {s_q.config_r[`NEP_CFG_PGSEL], s_q.tgt[7:3], s_q.cnt};
        end
        s_d.cnt = s_q.cnt + 3'd1;
        if (s_q.cnt == 3'd7) begin
          s_d.st = NEP_IDLE;
          s_d.done = 1'b1;
        end
      end
      default: s_d.st = NEP_IDLE;
    endcase
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.st <= NEP_IDLE;
      s_q.config_r <= `NEP_CFG_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  nep_array u_array (
    .pclk(pclk),
    .req(mreq),
    .rdata(mem_rdata)
  );

  // key bytes live outside the register space, one per key range address
  nep_keystore u_key (
    .pclk(pclk),
    .presetn(presetn),
    .we(key_we),
    .idx(key_idx),
    .wdata(key_wdata),
    .key(backdoor_compare_key)
  );

  // divider locks after its first write; no operation runs before it
  div_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(s_q.clkdiv[`NEP_DIV_LOADED]) |-> s_q.clkdiv == $past(s_q.clkdiv))
    else $error("divider changed after lock");
  no_op_nodiv_a: assert property (@(posedge pclk) disable iff (!presetn)
    !s_q.clkdiv[`NEP_DIV_LOADED] |=> s_q.st == NEP_IDLE)
    else $error("operation started without divider");
  div_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc && pwrite && paddr == `NEP_OFF_COMMAND && !s_q.clkdiv[`NEP_DIV_LOADED] |=>
    s_q.div_err)
    else $error("early command not flagged");

  // erase walks eight bytes, each written with the erased value
  erase_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.st == NEP_IDLE ##1 s_q.st == NEP_ERASE |-> s_q.st == NEP_ERASE [*8] ##1
    s_q.st == NEP_IDLE)
    else $error("erase not eight bytes");
  erase_ff_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.st == NEP_ERASE |-> mreq.we && mreq.wdata == `NEP_ERASED)
    else $error("erase wrote a non-erased value");
  erase_all_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.st == NEP_ERASE && !s_q.options[`NEP_OPT_SECMODE] |-> mreq.addr[2:0] == s_q.cnt)
    else $error("mode 0 erase skipped a byte");
  erase_fg_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.st == NEP_ERASE && s_q.options[`NEP_OPT_SECMODE] |->
    mreq.addr[8] == s_q.config_r[`NEP_CFG_PGSEL])
    else $error("mode 1 erase left the foreground");

  // key range decode: command start or key byte, never both
  key_cmd_a: assert property (@(posedge pclk) disable iff (!presetn)
    cw_rise && in_key && !s_q.config_r[`NEP_CFG_KEYWEN] |=> flash_cmd_start)
    else $error("key range write did not start command");
  key_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    cw_rise && in_key && s_q.config_r[`NEP_CFG_KEYWEN] |=> !flash_cmd_start)
    else $error("key write started command");
  cmd_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    flash_cmd_start |=> !flash_cmd_start)
    else $error("command start longer than one cycle");
  key_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !key_we |=> $stable(backdoor_compare_key))
    else $error("compare key changed without a key write");

  // page and sector mapping of window reads and programs
  page_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    eeprom_page_select == s_q.config_r[`NEP_CFG_PGSEL])
    else $error("page select output mismatch");
  mode1_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.options[`NEP_OPT_SECMODE] |-> ee_phys[8] == s_q.config_r[`NEP_CFG_PGSEL])
    else $error("mode 1 page bit wrong");
  mode0_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    !s_q.options[`NEP_OPT_SECMODE] |-> ee_phys[2] == s_q.config_r[`NEP_CFG_PGSEL])
    else $error("mode 0 half bit wrong");
  prog_m0_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.st == NEP_RUN && s_q.tmr == 5'd0 && !s_q.options[`NEP_OPT_SECMODE] |->
    mreq.we && mreq.addr[2] == s_q.config_r[`NEP_CFG_PGSEL])
    else $error("mode 0 program missed the foreground half");
  prog_m1_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.st == NEP_RUN && s_q.tmr == 5'd0 && s_q.options[`NEP_OPT_SECMODE] |->
    mreq.we && mreq.addr[8] == s_q.config_r[`NEP_CFG_PGSEL])
    else $error("mode 1 program missed the foreground page");

  // nonvolatile copy after reset and bus answer timing
  strap_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    !s_q.strap_done |=> s_q.options == $past(nv_options))
    else $error("options not copied after reset");
  strap_cfg_a: assert property (@(posedge pclk) disable iff (!presetn)
    !s_q.strap_done |=> s_q.config_r[`NEP_CFG_PGSEL] == $past(nv_config[`NEP_CFG_PGSEL]))
    else $error("page select not copied after reset");
  reg_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && paddr < `NEP_OFF_EE_BASE |-> pready)
    else $error("register access stalled");
  win_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup_w && !pwrite && paddr >= `NEP_OFF_EE_BASE ##1 psel && penable |-> !pready)
    else $error("window read did not wait for the array");
endmodule

// ==== nep_params.svh ====
// constants for the eeprom page control block: offsets, fields, resets, timing
`ifndef NEP_PARAMS_SVH
`define NEP_PARAMS_SVH

// apb byte offsets of the seven high-page registers
`define NEP_OFF_CLKDIV 12'h000
`define NEP_OFF_OPTIONS 12'h004
`define NEP_OFF_CONFIG 12'h008
`define NEP_OFF_STATUS 12'h00C
`define NEP_OFF_COMMAND 12'h010
`define NEP_OFF_KEY_ADDR 12'h014
`define NEP_OFF_KEY_DATA 12'h018
// processor-side window: eeprom array, flash key range
`define NEP_OFF_EE_BASE 12'h800
`define NEP_CPU_KEY_LO 16'hFFB0
`define NEP_CPU_KEY_HI 16'hFFB7
// field positions
`define NEP_CFG_PGSEL 6
`define NEP_CFG_KEYWEN 5
`define NEP_OPT_SECMODE 7
`define NEP_DIV_LOADED 7
`define NEP_ST_DIVERR 4
`define NEP_ST_BUSY 6
`define NEP_ST_DONE 7
// command codes
`define NEP_CMD_PROGRAM 8'h20
`define NEP_CMD_SECT_ERASE 8'h40
// erased byte value and reset values
`define NEP_ERASED 8'hFF
`define NEP_CFG_RESET 8'h00
// operation duration
`define NEP_OP_TIME_NS 100
`define NEP_CLK_PERIOD_NS 5
`define NEP_OP_CYCLES ((`NEP_OP_TIME_NS + `NEP_CLK_PERIOD_NS - 1) / `NEP_CLK_PERIOD_NS)

`endif

// ==== nep_pkg.sv ====
// types shared by the eeprom page control block
package nep_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } nep_apb_req_t;

  typedef struct packed {
    logic we;
    logic [8:0] addr;
    logic [7:0] wdata;
  } nep_mem_req_t;

  typedef enum logic [2:0] {
    NEP_IDLE = 3'b001,
    NEP_RUN = 3'b010,
    NEP_ERASE = 3'b100
  } nep_state_t;
endpackage

// ==== nep_array.sv ====
// eeprom byte array, 512 entries, registered read data
`timescale 1ns/10ps
module nep_array
  import nep_pkg::*;
(
  input wire logic pclk,
  input wire nep_mem_req_t req,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:511];

  // no reset on the array itself; erase is done by the controller
  always_ff @(posedge pclk) begin
    if (req.we) begin
      mem[req.addr] <= req.wdata;
    end
    rdata <= mem[req.addr];
  end
endmodule

// ==== nep_keystore.sv ====
// 8-byte backdoor compare key storage
`timescale 1ns/10ps
module nep_keystore
  import nep_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we,
  input wire logic [2:0] idx,
  input wire logic [7:0] wdata,
  output logic [63:0] key
);
  // one flop byte per key slot
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_byte
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          key[g*8 +: 8] <= 8'hFF;
        end else if (we && idx == 3'(g)) begin
          key[g*8 +: 8] <= wdata;
        end
      end
    end
  endgenerate
endmodule

// ==== nep_cpu_model.sv ====
// processor model that writes through the asynchronous cpu port
`timescale 1ns/10ps
module nep_cpu_model (
  input wire logic pclk,
  input wire logic go,
  input wire logic [15:0] addr,
  input wire logic [7:0] data,
  output logic [15:0] cpu_addr,
  output logic [7:0] cpu_wdata,
  output logic cpu_write,
  output logic done
);
  int cnt = 0;
  initial begin
    cpu_addr = 16'h0000;
    cpu_wdata = 8'h00;
    cpu_write = 1'h0;
    done = 1'h0;
  end
  // write stays high past the three-flop sync before the bus is let go
  always @(posedge pclk) begin
    done <= 1'h0;
    if (cnt == 0 && go === 1'h1) begin
      cpu_addr <= addr;
      cpu_wdata <= data;
      cpu_write <= 1'h1;
      cnt <= 1;
    end else if (cnt == 8) begin
      cpu_write <= 1'h0;
      cpu_addr <= ~cpu_addr; // released bus must not show the old address
      cpu_wdata <= ~cpu_wdata;
      cnt <= cnt + 1;
    end else if (cnt == 16) begin
      done <= 1'h1;
      cnt <= 0;
    end else if (cnt != 0) begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ==== nvm_eeprom_page_control_bench.sv ====
// self-checking bench for the eeprom page control block
`timescale 1ns/10ps
`include "nep_params.svh"
module nvm_eeprom_page_control_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cpu_write, go, cpu_done;
  logic flash_cmd_start, eeprom_page_select, sector_mapping_mode_bit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] nv_options, nv_config, cpu_wdata, flash_cmd_data, c_data;
  logic [15:0] cpu_addr, c_addr;
  logic [2:0] flash_cmd_index;
  logic [63:0] backdoor_compare_key;
  logic err;
  logic [10:0] last_cmd;
  int fail_count = 0;
  int compares = 0;
  int pulses = 0;

  nep_ctrl DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nv_options(nv_options), .nv_config(nv_config),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_write(cpu_write),
    .flash_cmd_start(flash_cmd_start), .flash_cmd_index(flash_cmd_index),
    .flash_cmd_data(flash_cmd_data), .backdoor_compare_key(backdoor_compare_key),
    .eeprom_page_select(eeprom_page_select),
    .sector_mapping_mode_bit(sector_mapping_mode_bit));
  nep_cpu_model cpu (.pclk(pclk), .go(go), .addr(c_addr), .data(c_data),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_write(cpu_write), .done(cpu_done));

  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end
  // record every command pulse the key range decode raises
  always @(posedge pclk) begin
    if (flash_cmd_start === 1'h1) begin
      pulses++;
      last_cmd = {flash_cmd_index, flash_cmd_data};
    end
  end

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic timeout();
    fail_count++;
    $display("wait bound used up");
    summarize();
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) timeout();
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(what, {32'h0, exp}, {32'h0, rd});
  endtask
  function automatic logic [11:0] ea(input logic [7:0] off);
    return `NEP_OFF_EE_BASE + {2'h0, off, 2'h0};
  endfunction
  task automatic pg(input logic p);
    apb(1'h1, `NEP_OFF_CONFIG, p ? 32'h40 : 32'h0);
  endtask
  // start a command and poll for done, then clear it
  task automatic op(input logic [7:0] cmd, input logic [7:0] off, input logic [7:0] dat);
    int n;
    n = 0;
    apb(1'h1, `NEP_OFF_KEY_ADDR, {24'h0, off});
    apb(1'h1, `NEP_OFF_KEY_DATA, {24'h0, dat});
    apb(1'h1, `NEP_OFF_COMMAND, {24'h0, cmd});
    do begin
      apb(1'h0, `NEP_OFF_STATUS, 32'h0);
      n++;
      if (n > 40) timeout();
    end while (rd[`NEP_ST_DONE] !== 1'h1);
    apb(1'h1, `NEP_OFF_STATUS, 32'h80);
  endtask
  task automatic cw(input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    c_addr <= a;
    c_data <= d;
    go <= 1'h1;
    @(posedge pclk);
    go <= 1'h0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 40) timeout();
    end while (cpu_done !== 1'h1);
  endtask
  task automatic rst(input logic [7:0] opt, input logic [7:0] cfg);
    presetn <= 1'h0;
    nv_options <= opt;
    nv_config <= cfg;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, go} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    nv_options = 8'h80;
    nv_config = 8'h40;
    c_addr = 16'h0000;
    c_data = 8'h00;
    rst(8'h80, 8'h40);
    chk("page select", 64'h1, eeprom_page_select);
    chk("sector mode", 64'h1, sector_mapping_mode_bit);
    chk("key reset", {8{8'hFF}}, backdoor_compare_key);
    rdc("config", `NEP_OFF_CONFIG, 32'h40);
    apb(1'h1, `NEP_OFF_OPTIONS, 32'h0);
    rdc("options", `NEP_OFF_OPTIONS, 32'h80);
    chk("mapped err", 64'h0, err);
    rdc("unmapped", 12'h01C, 32'h0);
    chk("unmapped err", 64'h1, err);
    apb(1'h1, `NEP_OFF_COMMAND, {24'h0, `NEP_CMD_PROGRAM});
    rdc("early command", `NEP_OFF_STATUS, 32'h10);
    apb(1'h1, `NEP_OFF_STATUS, 32'h10);
    apb(1'h1, `NEP_OFF_CLKDIV, 32'h13);
    rdc("divider", `NEP_OFF_CLKDIV, 32'h93);
    apb(1'h1, `NEP_OFF_CLKDIV, 32'h05);
    rdc("divider again", `NEP_OFF_CLKDIV, 32'h93);
    $display("test registers done");
    // eight-byte sectors: pages hold separate sectors
    pg(1'h0);
    op(`NEP_CMD_SECT_ERASE, 8'h00, 8'h00);
    op(`NEP_CMD_PROGRAM, 8'h03, 8'hA5);
    rdc("m1 p0 b3", ea(8'h03), 32'hA5);
    pg(1'h1);
    op(`NEP_CMD_SECT_ERASE, 8'h00, 8'h00);
    rdc("m1 p1 b3", ea(8'h03), 32'hFF);
    op(`NEP_CMD_PROGRAM, 8'h03, 8'h5A);
    pg(1'h0);
    rdc("m1 p0 keep", ea(8'h03), 32'hA5);
    op(`NEP_CMD_SECT_ERASE, 8'h00, 8'h00);
    rdc("m1 p0 erased", ea(8'h03), 32'hFF);
    pg(1'h1);
    rdc("m1 p1 kept", ea(8'h03), 32'h5A);
    $display("test eight-byte mode done");
    pg(1'h0);
    cw(16'hFFB2, 8'h3C);
    chk("cmd pulses", 64'h1, pulses);
    chk("cmd fields", {53'h0, 3'h2, 8'h3C}, last_cmd);
    chk("key kept", {8{8'hFF}}, backdoor_compare_key);
    cw(16'hFFB8, 8'h11);
    chk("outside range", 64'h1, pulses);
    apb(1'h1, `NEP_OFF_CONFIG, 32'h20);
    cw(16'hFFB7, 8'h77);
    chk("key byte7", {8'h77, {7{8'hFF}}}, backdoor_compare_key);
    chk("no pulse", 64'h1, pulses);
    $display("test key range done");
    // four-byte sectors: both pages share one physical sector
    rst(8'h00, 8'h00);
    chk("mode 0", 64'h0, sector_mapping_mode_bit);
    chk("key cleared", {8{8'hFF}}, backdoor_compare_key);
    apb(1'h1, `NEP_OFF_CLKDIV, 32'h7F);
    rdc("divider 2", `NEP_OFF_CLKDIV, 32'hFF);
    op(`NEP_CMD_SECT_ERASE, 8'h00, 8'h00);
    op(`NEP_CMD_PROGRAM, 8'h01, 8'h11);
    pg(1'h1);
    rdc("m0 p1 b1", ea(8'h01), 32'hFF);
    op(`NEP_CMD_PROGRAM, 8'h01, 8'h22);
    rdc("m0 p1 prog", ea(8'h01), 32'h22);
    pg(1'h0);
    rdc("m0 p0 keep", ea(8'h01), 32'h11);
    op(`NEP_CMD_SECT_ERASE, 8'h00, 8'h00);
    rdc("m0 p0 erased", ea(8'h01), 32'hFF);
    pg(1'h1);
    rdc("m0 p1 erased", ea(8'h01), 32'hFF);
    $display("test four-byte mode done");
    summarize();
  end
endmodule
